//--- hw/oosw_ctrl.sv
// On/off switcher control state machine with protection
module oosw_ctrl #(
  parameter longint RETRY_CYC = oosw_pkg::RETRY_WINDOW_CYC,
  parameter longint OFF_CYC = oosw_pkg::RESTART_OFF_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic sense_below_threshold,
  input wire logic sense_fault_low,
  input wire logic sense_current_low,
  input wire logic over_temp,
  input wire logic temp_recovered,
  input wire logic current_over_limit,
  output logic gate_on,
  output logic low_current_limit,
  output logic hold_charge_en,
  output logic restart_active,
  output logic open_loop,
  output logic thermal_shutdown
);
  // ========================================================================
  // Synchronised comparator inputs
  localparam int NIN = 6;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn_in;
  assign raw_in = {current_over_limit, temp_recovered, over_temp,
                   sense_current_low, sense_fault_low, sense_below_threshold};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++)
    begin : g_sync
      oosw_sync u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .din(raw_in[gi]),
        .dout(syn_in[gi])
      );
    end
  endgenerate
  logic fb_low;
  logic fb_fault;
  logic fb_i_low;
  logic t_hot;
  logic t_cool;
  logic i_over;
  assign fb_low = syn_in[0];
  assign fb_fault = syn_in[1];
  assign fb_i_low = syn_in[2];
  assign t_hot = syn_in[3];
  assign t_cool = syn_in[4];
  assign i_over = syn_in[5];

  // ========================================================================
  // State
  typedef struct packed {
    oosw_pkg::oosw_mode_t mode;
    logic [oosw_pkg::SUB_W-1:0] phase;
    logic gate;
    logic cycle_ended;
    logic enable_next;
    logic decided;
    logic [oosw_pkg::SKIP_W-1:0] skips;
    logic light;
    logic [oosw_pkg::CNT_W-1:0] fault_cnt;
    logic [oosw_pkg::CNT_W-1:0] off_cnt;
    logic [oosw_pkg::SKIP_W-1:0] ol_periods;
    logic open_loop;
    logic restart;
  } oosw_state_t;
  oosw_state_t st_r;
  oosw_state_t st_nxt;

  // ========================================================================
  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    if (st_r.phase == oosw_pkg::SUB_W'(oosw_pkg::OSC_CYC - 1))
    begin
      st_nxt.phase = '0;
    end
    else
    begin
      st_nxt.phase = st_r.phase + 1'b1;
    end
    unique case (st_r.mode)
      oosw_pkg::OOSW_RUN:
      begin
        // Period start: apply decision made at the last sample [RULE12] [RULE1]
        if (st_r.phase == '0)
        begin
          st_nxt.gate = st_r.enable_next;
          st_nxt.cycle_ended = !st_r.enable_next;
          st_nxt.decided = 1'b0;
          if (st_r.enable_next)
          begin
            st_nxt.skips = '0;
            st_nxt.light = 1'b0; // [RULE3]
          end
          else if (st_r.skips != oosw_pkg::SKIP_W'(oosw_pkg::LIGHT_SKIPS))
          begin
            st_nxt.skips = st_r.skips + 1'b1;
          end
          else
          begin
            st_nxt.light = 1'b1; // [RULE3]
          end
          if (st_r.enable_next)
          begin
            st_nxt.enable_next = 1'b0;
          end
        end
        else if (st_r.gate)
        begin
          // Current limit after blanking ends the cycle [RULE9] [RULE10]
          if ((i_over && st_r.phase >= oosw_pkg::SUB_W'(oosw_pkg::BLANK_CYC)) ||
              st_r.phase == oosw_pkg::SUB_W'(oosw_pkg::MAX_ON_CYC))
          begin
            st_nxt.gate = 1'b0;
            st_nxt.cycle_ended = 1'b1;
          end
          // Low feedback current during on-time means open loop [RULE7]
          if (fb_i_low)
          begin
            st_nxt.open_loop = 1'b1;
          end
        end
        // Off edge restarts the sample delay timer [RULE2]
        if (st_r.gate && !st_nxt.gate)
        begin
          st_nxt.off_cnt = '0;
        end
        // Sample a fixed delay after the off edge (skipped cycles: after period start)
        if (st_r.cycle_ended && !st_r.decided)
        begin
          st_nxt.off_cnt = st_r.off_cnt + 1'b1;
          if (st_r.off_cnt == oosw_pkg::CNT_W'(oosw_pkg::SAMPLE_DELAY_CYC - 1))
          begin
            st_nxt.enable_next = fb_low; // [RULE2] [RULE1]
            st_nxt.decided = 1'b1;
            st_nxt.off_cnt = '0;
          end
        end
        // Continuous low flyback feedback runs the retry window [RULE4] [RULE7]
        if (fb_fault)
        begin
          st_nxt.fault_cnt = st_r.fault_cnt + 1'b1;
        end
        else
        begin
          st_nxt.fault_cnt = '0;
        end
        if (st_r.phase == '0 && st_r.open_loop)
        begin
          st_nxt.ol_periods = st_r.ol_periods + 1'b1;
        end
        if (st_r.fault_cnt >= oosw_pkg::CNT_W'(RETRY_CYC) ||
            st_r.ol_periods >= oosw_pkg::SKIP_W'(oosw_pkg::OPEN_LOOP_PERIODS))
        begin
          st_nxt.mode = oosw_pkg::OOSW_OFF; // [RULE5]
          st_nxt.gate = 1'b0;
          st_nxt.restart = 1'b1;
          st_nxt.off_cnt = '0;
        end
      end
      oosw_pkg::OOSW_OFF:
      begin
        // Hold off, then retry a fresh window [RULE5] [RULE6]
        st_nxt.gate = 1'b0;
        st_nxt.off_cnt = st_r.off_cnt + 1'b1;
        if (st_r.off_cnt == oosw_pkg::CNT_W'(OFF_CYC - 1))
        begin
          st_nxt.mode = oosw_pkg::OOSW_RUN;
          st_nxt.phase = '0;
          st_nxt.off_cnt = '0;
          st_nxt.fault_cnt = '0;
          st_nxt.ol_periods = '0;
          st_nxt.open_loop = 1'b0;
          st_nxt.restart = 1'b0;
          st_nxt.enable_next = 1'b1;
          st_nxt.cycle_ended = 1'b0;
          st_nxt.decided = 1'b0;
        end
      end
      oosw_pkg::OOSW_HOT:
      begin
        // Stay off until cooled by the hysteresis [RULE8]
        st_nxt.gate = 1'b0;
        if (t_cool && !t_hot)
        begin
          st_nxt.mode = oosw_pkg::OOSW_RUN;
          st_nxt.phase = '0;
          st_nxt.enable_next = 1'b1;
          st_nxt.decided = 1'b0;
          st_nxt.fault_cnt = '0;
          // Drop timers and flags left by a cycle or restart cut short by heat
          st_nxt.off_cnt = '0;
          st_nxt.ol_periods = '0;
          st_nxt.open_loop = 1'b0;
          st_nxt.restart = 1'b0;
          st_nxt.cycle_ended = 1'b0;
        end
      end
      default:
      begin
        st_nxt.mode = oosw_pkg::OOSW_RUN;
        st_nxt.gate = 1'b0;
      end
    endcase
    // Thermal shutdown overrides mode and gate in every state [RULE8]
    if (t_hot)
    begin
      st_nxt.mode = oosw_pkg::OOSW_HOT;
      st_nxt.gate = 1'b0;
    end
    // Open loop flag shortens the window to whole periods [RULE7]
    if (fb_i_low && st_r.gate)
    begin
      st_nxt.open_loop = 1'b1;
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '{mode: oosw_pkg::OOSW_RUN, enable_next: 1'b1, default: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // Registered outputs
  logic gate_r;
  logic low_lim_r;
  logic charge_r;
  logic rst_r;
  logic ol_r;
  logic hot_r;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_r <= 1'b0;
      low_lim_r <= 1'b0;
      charge_r <= 1'b1;
      rst_r <= 1'b0;
      ol_r <= 1'b0;
      hot_r <= 1'b0;
    end
    else
    begin
      gate_r <= st_nxt.gate;
      low_lim_r <= st_nxt.light; // [RULE3]
      charge_r <= !st_nxt.gate; // [RULE11]
      rst_r <= st_nxt.restart;
      ol_r <= st_nxt.open_loop;
      hot_r <= (st_nxt.mode == oosw_pkg::OOSW_HOT);
    end
  end
  assign gate_on = gate_r;
  assign low_current_limit = low_lim_r;
  assign hold_charge_en = charge_r;
  assign restart_active = rst_r;
  assign open_loop = ol_r;
  assign thermal_shutdown = hot_r;
endmodule // oosw_ctrl

//--- hw/oosw_pkg.sv
// Constants and types shared by the on/off switcher control block
// ==========================================================================
// What this block does
// RULE1 - Regulate feedback by enabling or skipping whole switching cycles, not pulse width.
// RULE2 - Sample feedback a fixed 2.5 us after switch turn-off each cycle.
// RULE3 - Select a lower current limit at light load.
// RULE4 - Enter auto-restart when feedback stays low over 200 ms continuously.
// RULE5 - In auto-restart, hold the switch off for 2.5 s.
// RULE6 - Alternate retry window and off period until fault clears, then regulate.
// RULE7 - Low feedback current declares open loop; window shrinks to 6 oscillator cycles.
// RULE8 - Thermal shutdown above 142 C, resume after 60 C drop.
// RULE9 - Over-limit current ends conduction for the rest of the cycle.
// RULE10 - Ignore the current-limit comparator during blanking after turn-on.
// RULE11 - Charge the supply-hold node from drain only while the switch is off.
// RULE12 - Skipped cycle holds gate off one period; decision applies at next cycle start.
// ==========================================================================
package oosw_pkg;
  // Clock rate in kHz
  localparam int CLK_KHZ = 100000;
  // Oscillator period (15 us, so 6 cycles are 90 us)
  localparam int OSC_PERIOD_NS = 15000;
  localparam int OSC_CYC = OSC_PERIOD_NS * CLK_KHZ / 1000000;
  // Maximum on-time within a period
  localparam int MAX_ON_NS = 10000;
  localparam int MAX_ON_CYC = MAX_ON_NS * CLK_KHZ / 1000000;
  // Feedback sampling delay after turn-off
  localparam int SAMPLE_DELAY_NS = 2500;
  localparam int SAMPLE_DELAY_CYC = SAMPLE_DELAY_NS * CLK_KHZ / 1000000;
  // Leading-edge blanking time
  localparam int BLANK_NS = 200;
  localparam int BLANK_CYC = (BLANK_NS * CLK_KHZ + 999999) / 1000000;
  // Auto-restart timing
  localparam int RETRY_WINDOW_MS = 200;
  localparam longint RETRY_WINDOW_CYC = longint'(RETRY_WINDOW_MS) * CLK_KHZ;
  localparam int RESTART_OFF_MS = 2500;
  localparam longint RESTART_OFF_CYC = longint'(RESTART_OFF_MS) * CLK_KHZ;
  localparam int OPEN_LOOP_PERIODS = 6;
  // Light load: one more than this many skipped cycles in a row selects the low limit
  localparam int LIGHT_SKIPS = 4;
  localparam int CNT_W = 32;
  localparam int SUB_W = 16;
  localparam int SKIP_W = 4;
  // Control modes
  typedef enum logic [1:0] {
    OOSW_RUN = 2'b00,
    OOSW_OFF = 2'b01,
    OOSW_HOT = 2'b10
  } oosw_mode_t;
endpackage : oosw_pkg

//--- hw/oosw_sync.sv
// Three-stage input synchroniser with agreement filter
module oosw_sync (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic [2:0] sh_r;
  logic out_r;
  // ========================================================================
  // Shift chain; output moves once stages two and three agree
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sh_r <= 3'h0;
      out_r <= 1'b0;
    end
    else
    begin
      sh_r <= {sh_r[1:0], din};
      if (sh_r[1] == sh_r[2])
      begin
        out_r <= sh_r[2];
      end
    end
  end
  assign dout = out_r;
endmodule // oosw_sync

//--- sim/oosw_ctrl_sva.sv
// Port checker for the on/off switcher control block
module oosw_ctrl_sva #(
  parameter longint OFF_CYC = 5000
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic over_temp,
  input wire logic current_over_limit,
  input wire logic gate_on,
  input wire logic low_current_limit,
  input wire logic hold_charge_en,
  input wire logic restart_active,
  input wire logic open_loop,
  input wire logic thermal_shutdown
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] gap_r;
  logic [15:0] on_r;
  logic [31:0] off_r;
  // ==========================================
  // Cycles since turn-on, on-time and off period length
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_r <= 16'hffff;
      on_r <= 16'h0;
      off_r <= 32'h0;
    end
    else
    begin
      gap_r <= $rose(gate_on) ? 16'h1 : gap_r + {15'h0, gap_r != 16'hffff};
      on_r <= gate_on ? on_r + 16'h1 : 16'h0;
      off_r <= restart_active ? off_r + 32'h1 : 32'h0;
    end
  end
  a_charge_while_off: assert property (hold_charge_en == !gate_on)
    else $error("hold charging overlaps gate");
  a_restart_gate_off: assert property (restart_active |-> !gate_on)
    else $error("gate on during restart");
  a_hot_gate_off: assert property (thermal_shutdown |-> !gate_on)
    else $error("gate on while hot");
  a_hot_entry: assert property (over_temp [*8] |=> thermal_shutdown)
    else $error("no thermal shutdown");
  a_blank_hold: assert property ($rose(gate_on) |=> (gate_on || restart_active || thermal_shutdown) [*8])
    else $error("gate cut inside blanking");
  a_limit_cuts: assert property (current_over_limit [*8] ##0 on_r > 16'd30 |-> !gate_on)
    else $error("limit did not end conduction");
  a_turn_on_spacing: assert property ($rose(gate_on) |-> gap_r >= oosw_pkg::OSC_CYC - 2)
    else $error("turn-on inside a period");
  a_restart_length: assert property ($fell(restart_active) |-> off_r >= OFF_CYC - 2 && off_r <= OFF_CYC + 2)
    else $error("restart off period length wrong");
  c_limit_cut: cover property (current_over_limit && $fell(gate_on));
  c_open_loop: cover property ($rose(open_loop));
  c_light_load: cover property ($rose(low_current_limit));
endmodule // oosw_ctrl_sva

bind oosw_ctrl oosw_ctrl_sva #(.OFF_CYC(OFF_CYC)) u_oosw_ctrl_sva (.core_clk(core_clk), .resetn(resetn),
  .over_temp(over_temp), .current_over_limit(current_over_limit), .gate_on(gate_on),
  .low_current_limit(low_current_limit), .hold_charge_en(hold_charge_en), .restart_active(restart_active),
  .open_loop(open_loop), .thermal_shutdown(thermal_shutdown));

//--- sim/oosw_winding.sv
// Behavioural bias winding and feedback divider model
module oosw_winding (
  input wire logic core_clk,
  input wire logic gate_on,
  input wire logic [1:0] mode,
  input wire logic [7:0] load,
  output logic sense_below_threshold,
  output logic sense_fault_low,
  output logic sense_current_low
);
  timeunit 1ns;
  timeprecision 1ps;
  int lvl = 0;
  // ==========================================
  // Output charge rises with conduction, drains with load
  always @(posedge core_clk)
  begin
    lvl <= gate_on ? lvl + 8 : (lvl > load ? lvl - load : 0);
  end
  // Mode 1 is a shorted output, mode 2 an open divider
  assign sense_below_threshold = (mode != 2'h0) || (lvl < 1000);
  assign sense_fault_low = (mode == 2'h1);
  assign sense_current_low = (mode == 2'h2) && gate_on;
endmodule // oosw_winding

//--- sim/tb.sv
// Self-checking testbench for the on/off switcher control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic over_temp = 1'b0;
  logic temp_recovered = 1'b0;
  logic current_over_limit = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] load = 8'hff;
  logic sbt;
  logic sfl;
  logic scl;
  logic gate_on;
  logic low_current_limit;
  logic hold_charge_en;
  logic restart_active;
  logic open_loop;
  logic thermal_shutdown;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  always #5 core_clk = ~core_clk;
  oosw_ctrl #(.RETRY_CYC(2000), .OFF_CYC(5000)) u_oosw_ctrl (.core_clk(core_clk), .resetn(resetn),
    .sense_below_threshold(sbt), .sense_fault_low(sfl), .sense_current_low(scl), .over_temp(over_temp),
    .temp_recovered(temp_recovered), .current_over_limit(current_over_limit), .gate_on(gate_on),
    .low_current_limit(low_current_limit), .hold_charge_en(hold_charge_en), .restart_active(restart_active),
    .open_loop(open_loop), .thermal_shutdown(thermal_shutdown));
  oosw_winding u_oosw_winding (.core_clk(core_clk), .gate_on(gate_on), .mode(mode), .load(load),
    .sense_below_threshold(sbt), .sense_fault_low(sfl), .sense_current_low(scl));
  // ==========================================
  // Shared helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  // Bounded wait for a level; n returns the cycles taken
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim)
    begin
      tick(1);
      n++;
    end
    check(s, v);
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Current limit at turn-on: blanked, then ends the cycle
  task automatic t_limit();
    wait_for(gate_on, 1'b0, 1100);
    wait_for(gate_on, 1'b1, 1600);
    current_over_limit = 1'b1;
    tick(12);
    check(gate_on, 1'b1);
    check(hold_charge_en, 1'b0);
    tick(20);
    check(gate_on, 1'b0);
    check(hold_charge_en, 1'b1);
    current_over_limit = 1'b0;
    tick(300);
    check(gate_on, 1'b0);
    wait_for(gate_on, 1'b1, 1500);
    check(n > 1100, 1'b1);
  endtask
  // No load: cycles skipped, reduced limit chosen
  task automatic t_light();
    load = 8'h00;
    wait_for(low_current_limit, 1'b1, 20000);
    check(gate_on, 1'b0);
    load = 8'hff;
    wait_for(low_current_limit, 1'b0, 20000);
  endtask
  // Shorted output: retry window, off period, recovery
  task automatic t_short();
    mode = 2'h1;
    wait_for(restart_active, 1'b1, 2100);
    check(n > 1900, 1'b1);
    wait_for(restart_active, 1'b0, 5100);
    check(n >= 4990, 1'b1);
    wait_for(gate_on, 1'b1, 1600);
    mode = 2'h0;
    tick(4000);
    check(restart_active, 1'b0);
  endtask
  // Open divider: six-period window, same off period
  task automatic t_open();
    mode = 2'h2;
    wait_for(open_loop, 1'b1, 3100);
    wait_for(restart_active, 1'b1, 9100);
    check(n > 7400, 1'b1);
    tick(4000);
    mode = 2'h0;
    wait_for(restart_active, 1'b0, 1100);
    check(n >= 990, 1'b1);
    tick(3000);
    check(open_loop, 1'b0);
  endtask
  // Overheat: off until recovered, then switching again
  task automatic t_hot();
    over_temp = 1'b1;
    wait_for(thermal_shutdown, 1'b1, 10);
    tick(6); // Hold the trip long enough for the entry checker
    over_temp = 1'b0;
    tick(1600);
    check(gate_on, 1'b0);
    temp_recovered = 1'b1;
    wait_for(thermal_shutdown, 1'b0, 10);
    wait_for(gate_on, 1'b1, 1600);
  endtask
  initial
  begin
    tick(2);
    check(gate_on, 1'b0);
    check(hold_charge_en, 1'b1);
    resetn = 1'b1;
    t_limit();
    t_light();
    t_short();
    t_open();
    t_hot();
    tally_and_finish();
  end
  // Watchdog against a hang
  initial
  begin
    #900us;
    num_errors++;
    tally_and_finish();
  end
endmodule // tb
